// ===== shared/acg_defs.svh
// acg_defs: register offsets, field positions and reset values
`ifndef ACG_DEFS_SVH
`define ACG_DEFS_SVH
`define ACG_REG_DELAY       8'h05
`define ACG_REG_LEN         8'h06
`define ACG_REG_GAIN0       8'h08
`define ACG_REG_SHIFT0      8'h0B
`define ACG_REG_SOG         8'h0F
`define ACG_REG_SYNC        8'h10
`define ACG_REG_CLSEL       8'h11
`define ACG_REG_STAT        8'h1A
`define ACG_SOG_THR_HI      7
`define ACG_SOG_THR_LO      3
`define ACG_HPOL_BIT        6
`define ACG_SRC_GREEN_BIT   3
`define ACG_CLSEL_LO        4
`define ACG_RST_DELAY       8'h08
`define ACG_RST_LEN         8'h14
`define ACG_RST_GAIN        8'h80
`define ACG_RST_SHIFT       7'h00
`define ACG_RST_SOG         8'h78
`define ACG_RST_SYNC        8'h40
`define ACG_RST_CLSEL       8'h00
`define ACG_MID_CODE        8'h80
`define ACG_GND_CODE        8'h00
`define ACG_SHIFT_NEG_LIM   7'h40
`define ACG_SHIFT_NEG_SAT   7'h41
`define ACG_TRIM_MAX        8'h7F
`define ACG_TRIM_MIN        8'h81
`define ACG_RANGE_MIN_MV    10'h1F4
`define ACG_RANGE_MAX_MV    10'h3E8
`define ACG_STEP_MIN_UV     12'h7D0
`define ACG_STEP_MAX_UV     12'hFA0
`define ACG_GAIN_FULL       8'hFF
`define ACG_I2C_ADDR        7'h4C
`endif

// ===== shared/acg_pkg.sv
// acg_pkg: shared types for the clamp, gain and offset control block
`default_nettype none
package acg_pkg;
	typedef enum logic [1:0] {
		CL_IDLE  = 2'b00,
		CL_DELAY = 2'b01,
		CL_WIN   = 2'b10
	} acg_clamp_st_t;
	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_PTR  = 3'b010,
		I_DATA = 3'b011,
		I_RD   = 3'b100,
		I_ACK  = 3'b101,
		I_RACK = 3'b110
	} acg_i2c_st_t;
	typedef struct packed {
		logic       stb;
		logic [7:0] addr;
		logic [7:0] data;
	} acg_wr_t;
	typedef struct packed {
		logic [9:0]  range_mv;
		logic [11:0] step_uv;
		logic [6:0]  shift;
		logic [7:0]  trim;
		logic [7:0]  target;
	} acg_chan_out_t;
endpackage : acg_pkg
`default_nettype wire

// ===== core/acg_i2c_slave.sv
// acg_i2c_slave: two-wire serial register port with auto-increment
`default_nettype none
`include "acg_defs.svh"
module acg_i2c_slave
	import acg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `ACG_I2C_ADDR
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe,
	output acg_wr_t         wr,
	output logic [7:0]      rd_addr,
	input  wire logic [7:0] rd_data
);
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic start, stop, rise, fall, nack;
	acg_i2c_st_t st, ret;
	logic [3:0] bitc;
	logic [7:0] sr, tx, ptr;

	// pins are asynchronous: two stages before any logic looks at them
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
		end
	end

	assign start   = scl_s & scl_d & sda_d & ~sda_s;
	assign stop    = scl_s & scl_d & ~sda_d & sda_s;
	assign rise    = scl_s & ~scl_d;
	assign fall    = ~scl_s & scl_d;
	assign rd_addr = ptr;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st     <= I_IDLE;
			ret    <= I_IDLE;
			bitc   <= 4'h0;
			sr     <= 8'h00;
			tx     <= 8'h00;
			ptr    <= 8'h00;
			nack   <= 1'b0;
			sda_oe <= 1'b0;
		end else if (start) begin
			st     <= I_ADDR;
			bitc   <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop) begin
			st     <= I_IDLE;
			sda_oe <= 1'b0;
		end else if (rise) begin
			if (st == I_ADDR || st == I_PTR || st == I_DATA) begin
				sr   <= {sr[6:0], sda_s};
				bitc <= bitc + 4'h1;
			end
			if (st == I_RACK)
				nack <= sda_s;
		end else if (fall) begin
			unique case (st)
				I_IDLE: ;
				I_ADDR, I_PTR, I_DATA: if (bitc == 4'h8) begin
					bitc   <= 4'h0;
					st     <= I_ACK;
					sda_oe <= 1'b1;
					if (st == I_ADDR) begin
						ret <= sr[0] ? I_RD : I_PTR;
						// foreign address: stay off the line until next start
						if (sr[7:1] != DEV_ADDR) begin
							st     <= I_IDLE;
							sda_oe <= 1'b0;
						end
					end else if (st == I_PTR) begin
						ptr <= sr;
						ret <= I_DATA;
					end else begin
						ptr <= ptr + 8'h01;
						ret <= I_DATA;
					end
				end
				I_ACK: if (ret == I_RD) begin
					tx     <= rd_data;
					sda_oe <= ~rd_data[7];
					bitc   <= 4'h1;
					st     <= I_RD;
				end else begin
					sda_oe <= 1'b0;
					st     <= ret;
				end
				I_RD: if (bitc == 4'h8) begin
					sda_oe <= 1'b0;
					st     <= I_RACK;
					ptr    <= ptr + 8'h01;
				end else begin
					sda_oe <= ~tx[3'(4'h7 - bitc)];
					bitc   <= bitc + 4'h1;
				end
				I_RACK: if (nack) begin
					st <= I_IDLE;
				end else begin
					tx     <= rd_data;
					sda_oe <= ~rd_data[7];
					bitc   <= 4'h1;
					st     <= I_RD;
				end
				default: st <= I_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr <= '0;
		end else begin
			wr.stb  <= fall && !start && !stop && st == I_DATA && bitc == 4'h8;
			wr.addr <= ptr;
			wr.data <= sr;
		end
	end
endmodule : acg_i2c_slave
`default_nettype wire

// ===== core/acg_top.sv
// acg_top: clamp timing, clamp loop and gain, offset and slicer settings
//
// Operation
// - clamp starts placement count after trailing sync
// - clamp stays on for duration count
// - placement and duration are 8-bit unsigned
// - ground clamp drives black to code zero
// - per-converter midscale or ground target select
// - 8-bit gain maps linearly onto input range
// - 7-bit per-channel offset, plus or minus 63
// - offset step scales with full-scale range
// - five-bit slicer threshold field, bits 7:3
// - green sync always taken as negative polarity
`default_nettype none
`include "acg_defs.svh"
module acg_top
	import acg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `ACG_I2C_ADDR
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            scl_in,
	input  wire logic            sda_in,
	output logic                 sda_out,
	output logic                 sda_oe,
	input  wire logic            hsync_in,
	input  wire logic            green_sync_input,
	input  wire logic [2:0][7:0] adc_code,
	output logic                 clamp_active,
	output logic [4:0]           green_sync_threshold,
	output acg_chan_out_t [2:0]  chan_out
);
	if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad_addr
		$error("device address falls in a reserved group");
	end

	acg_wr_t        wr;
	logic [7:0]     rd_addr, rd_data;
	logic [7:0]     clamp_delay_count, clamp_window_length;
	logic [7:0]     green_sync_threshold_ctrl, sync_polarity_ctrl, clamp_level_select;
	logic [2:0][7:0] range_set;
	logic [2:0][6:0] shift_set;
	logic [2:0][7:0] trim;
	logic [2:0][7:0] target;
	logic           hs_m, hs_s, hs_d, gs_m, gs_s, gs_d;
	logic           hs_edge, src_green, hpol, line_seen;
	acg_clamp_st_t  st;
	logic [7:0]     cnt;

	function automatic logic [9:0] range_of(input logic [7:0] g);
		logic [17:0] p;
		p = 18'(g) * 18'(`ACG_RANGE_MAX_MV - `ACG_RANGE_MIN_MV);
		return `ACG_RANGE_MIN_MV + 10'(p / 18'(`ACG_GAIN_FULL));
	endfunction : range_of

	function automatic logic [11:0] step_of(input logic [7:0] g);
		logic [19:0] p;
		p = 20'(g) * 20'(`ACG_STEP_MAX_UV - `ACG_STEP_MIN_UV);
		return `ACG_STEP_MIN_UV + 12'(p / 20'(`ACG_GAIN_FULL));
	endfunction : step_of

	acg_i2c_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_port (
		.clk     (clk),
		.rst_n   (rst_n),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.sda_oe  (sda_oe),
		.wr      (wr),
		.rd_addr (rd_addr),
		.rd_data (rd_data)
	);

	// open drain: only ever pulls low
	assign sda_out = 1'b0;

	// power-up values follow the suggested starting point
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clamp_delay_count   <= `ACG_RST_DELAY;
			clamp_window_length <= `ACG_RST_LEN;
		end else if (wr.stb) begin
			if (wr.addr == `ACG_REG_DELAY)
				clamp_delay_count <= wr.data;
			if (wr.addr == `ACG_REG_LEN)
				clamp_window_length <= wr.data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			green_sync_threshold_ctrl <= `ACG_RST_SOG;
			sync_polarity_ctrl        <= `ACG_RST_SYNC;
			clamp_level_select        <= `ACG_RST_CLSEL;
		end else if (wr.stb) begin
			if (wr.addr == `ACG_REG_SOG)
				green_sync_threshold_ctrl <= wr.data;
			if (wr.addr == `ACG_REG_SYNC)
				sync_polarity_ctrl <= wr.data;
			if (wr.addr == `ACG_REG_CLSEL)
				clamp_level_select <= wr.data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int c = 0; c < 3; c++) begin
				range_set[c] <= `ACG_RST_GAIN;
				shift_set[c] <= `ACG_RST_SHIFT;
			end
		end else if (wr.stb) begin
			for (int c = 0; c < 3; c++) begin
				if (wr.addr == `ACG_REG_GAIN0 + 8'(c))
					range_set[c] <= wr.data;
				if (wr.addr == `ACG_REG_SHIFT0 + 8'(c))
					shift_set[c] <= wr.data[6:0];
			end
		end
	end

	always_comb begin
		rd_data = 8'h00;
		unique case (rd_addr)
			`ACG_REG_DELAY:       rd_data = clamp_delay_count;
			`ACG_REG_LEN:         rd_data = clamp_window_length;
			`ACG_REG_GAIN0:       rd_data = range_set[0];
			`ACG_REG_GAIN0 + 8'h1: rd_data = range_set[1];
			`ACG_REG_GAIN0 + 8'h2: rd_data = range_set[2];
			`ACG_REG_SHIFT0:      rd_data = {1'b0, shift_set[0]};
			`ACG_REG_SHIFT0 + 8'h1: rd_data = {1'b0, shift_set[1]};
			`ACG_REG_SHIFT0 + 8'h2: rd_data = {1'b0, shift_set[2]};
			`ACG_REG_SOG:         rd_data = green_sync_threshold_ctrl;
			`ACG_REG_SYNC:        rd_data = sync_polarity_ctrl;
			`ACG_REG_CLSEL:       rd_data = clamp_level_select;
			`ACG_REG_STAT:        rd_data = {5'h00, line_seen, st == CL_DELAY, clamp_active};
			default:              rd_data = 8'h00;
		endcase
	end

	assign green_sync_threshold =
		green_sync_threshold_ctrl[`ACG_SOG_THR_HI:`ACG_SOG_THR_LO];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{hs_m, hs_s, hs_d} <= 3'h0;
			{gs_m, gs_s, gs_d} <= 3'h7;
		end else begin
			{hs_m, hs_s, hs_d} <= {hsync_in, hs_m, hs_s};
			{gs_m, gs_s, gs_d} <= {green_sync_input, gs_m, gs_s};
		end
	end

	assign src_green = sync_polarity_ctrl[`ACG_SRC_GREEN_BIT];
	assign hpol      = sync_polarity_ctrl[`ACG_HPOL_BIT];
	// green sync ignores the polarity bit: its trailing edge is always a rise
	assign hs_edge = src_green ? (gs_s & ~gs_d)
		: (hpol ? (~hs_s & hs_d) : (hs_s & ~hs_d));

	always_ff @(posedge clk) begin
		if (!rst_n)
			line_seen <= 1'b0;
		else if (hs_edge)
			line_seen <= 1'b1;
	end

	// a new edge wins over any window in flight, so a short line never
	// carries a stale clamp into the next one
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st  <= CL_IDLE;
			cnt <= 8'h00;
		end else if (hs_edge) begin
			st  <= CL_DELAY;
			cnt <= 8'h00;
		end else begin
			unique case (st)
				CL_IDLE: ;
				CL_DELAY: if (cnt == clamp_delay_count) begin
					cnt <= 8'h00;
					st  <= (clamp_window_length == 8'h00) ? CL_IDLE : CL_WIN;
				end else begin
					cnt <= cnt + 8'h01;
				end
				CL_WIN: if (cnt == clamp_window_length - 8'h01) begin
					st <= CL_IDLE;
				end else begin
					cnt <= cnt + 8'h01;
				end
				default: st <= CL_IDLE;
			endcase
		end
	end

	assign clamp_active = (st == CL_WIN);

	// one code step per pixel: slow, but a single noisy sample moves trim by one code at most
	for (genvar c = 0; c < 3; c++) begin : g_chan
		assign target[c] = clamp_level_select[`ACG_CLSEL_LO + c]
			? `ACG_MID_CODE : `ACG_GND_CODE;
		always_ff @(posedge clk) begin
			if (!rst_n)
				trim[c] <= 8'h00;
			else if (clamp_active) begin
				if (adc_code[c] > target[c] && trim[c] != `ACG_TRIM_MIN)
					trim[c] <= trim[c] - 8'h01;
				else if (adc_code[c] < target[c] && trim[c] != `ACG_TRIM_MAX)
					trim[c] <= trim[c] + 8'h01;
			end
		end
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				chan_out[c] <= '0;
			end else begin
				chan_out[c].range_mv <= range_of(range_set[c]);
				chan_out[c].step_uv  <= step_of(range_set[c]);
				chan_out[c].shift    <= (shift_set[c] == `ACG_SHIFT_NEG_LIM)
					? `ACG_SHIFT_NEG_SAT : shift_set[c];
				chan_out[c].trim     <= trim[c];
				chan_out[c].target   <= target[c];
			end
		end
	end

	logic [8:0] edge_age, win_age;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			edge_age <= 9'h1FF;
			win_age  <= 9'h000;
		end else begin
			edge_age <= hs_edge ? 9'h000 : (edge_age == 9'h1FF ? edge_age : edge_age + 9'h001);
			win_age  <= clamp_active ? win_age + 9'h001 : 9'h000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_clamp_start_pos: assert property ($rose(clamp_active) && !$past(wr.stb)
		|-> edge_age == 9'(clamp_delay_count) + 9'h001)
		else $error("clamp window opened at the wrong pixel after sync");
	a_clamp_win_len: assert property ($fell(clamp_active) && !$past(hs_edge)
		&& !$past(wr.stb) |-> win_age == 9'(clamp_window_length))
		else $error("clamp window length differs from setting");
	a_delay_cnt_bound: assert property (st == CL_DELAY |-> cnt <= clamp_delay_count)
		else $error("placement counter ran past its setting");
	a_line_restart: assert property (hs_edge |=> st == CL_DELAY && cnt == 8'h00 ##1
		(hs_edge || clamp_delay_count == 8'h00 || st == CL_DELAY))
		else $error("counters did not restart on trailing sync edge");
	a_trim_down: assert property (clamp_active && adc_code[0] > target[0]
		&& trim[0] != `ACG_TRIM_MIN |=> trim[0] == $past(trim[0]) - 8'h01)
		else $error("clamp loop did not pull high code toward target");
	a_trim_hold: assert property (!clamp_active |=> $stable(trim))
		else $error("clamp trim moved outside the window");
	a_target_sel: assert property (##1 chan_out[1].target
		== ($past(clamp_level_select[`ACG_CLSEL_LO + 1]) ? `ACG_MID_CODE : `ACG_GND_CODE))
		else $error("clamp target does not follow level select");
	a_range_ends: assert property (range_set[2] == `ACG_GAIN_FULL
		|=> chan_out[2].range_mv == `ACG_RANGE_MAX_MV)
		else $error("full gain code does not give widest range");
	a_shift_span: assert property (chan_out[0].shift != `ACG_SHIFT_NEG_LIM)
		else $error("offset shift beyond minus 63");
	a_step_track: assert property (range_set[1] == 8'h00
		|=> chan_out[1].step_uv == `ACG_STEP_MIN_UV && chan_out[1].range_mv == `ACG_RANGE_MIN_MV)
		else $error("offset step not tied to range");
	a_thr_write: assert property (wr.stb && wr.addr == `ACG_REG_SOG
		|=> green_sync_threshold == $past(wr.data[7:3]))
		else $error("slicer threshold did not take written field");
	a_green_neg: assert property (src_green && gs_s && !gs_d |-> hs_edge)
		else $error("green sync rise not taken as trailing edge");

	c_full_window: cover property ($fell(clamp_active) && !$past(hs_edge));
	c_restart_mid: cover property (clamp_active && hs_edge);
	c_green_line: cover property (src_green && hs_edge);
	c_reg_write: cover property (wr.stb && wr.addr == `ACG_REG_DELAY);
endmodule : acg_top
`default_nettype wire

// ===== testbench/acg_src_model.sv
// acg_src_model: graphics source driving sync pins and converter codes
`default_nettype none
module acg_src_model (
	input  wire logic       clk,
	output logic            hsync_in,
	output logic            green_sync_input,
	output logic [2:0][7:0] adc_code
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hpol;
	initial begin
		hpol = 1'b1;
		hsync_in = 1'b0;
		green_sync_input = 1'b1;
		adc_code = {3{8'h80}};
	end
	// idle level follows the programmed polarity bit
	task automatic set_pol(input logic p);
		@(negedge clk);
		hpol = p;
		hsync_in = ~p;
	endtask : set_pol
	task automatic set_codes(input logic [2:0][7:0] v);
		@(negedge clk);
		adc_code = v;
	endtask : set_codes
	// four pixels active, then trailing edge; green sync pulses low
	task automatic line(input logic grn);
		@(negedge clk);
		if (grn) green_sync_input = 1'b0; else hsync_in = hpol;
		repeat (4) @(negedge clk);
		if (grn) green_sync_input = 1'b1; else hsync_in = ~hpol;
	endtask : line
endmodule : acg_src_model
`default_nettype wire

// ===== testbench/tb_adc_clamp_gain_offset_control.sv
// tb_adc_clamp_gain_offset_control: bench for the clamp, gain and offset block
`default_nettype none
`include "acg_defs.svh"
module tb_adc_clamp_gain_offset_control
	import acg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] d, n;
		logic [1:0] ch;
		logic [7:0] g;
		logic [6:0] s;
		logic [7:0] cl, th;
	} acg_row_t;
	logic                clk, rst_n, scl, sda_m, hsync_in, green_sync_input;
	logic                sda_oe, clamp_active;
	wire logic           sda_o;
	logic [2:0][7:0]     adc_code;
	logic [4:0]          green_sync_threshold;
	logic [7:0]          q;
	acg_chan_out_t [2:0] chan_out, snap;
	acg_chan_out_t       c;
	acg_row_t            x;
	int                  fail_count, comparisons, r, w, n;
	wire logic           sda_w = sda_m & ~sda_oe;
	logic [7:0] ra [6] = '{8'h05, 8'h06, 8'h0F, 8'h11, 8'h09, 8'h30};
	logic [7:0] rv [6] = '{8'h08, 8'h14, 8'h78, 8'h00, 8'h80, 8'h00};
	acg_row_t rows [4] = '{
		'{8'h08, 8'h14, 2'd0, 8'h00, 7'h3F, 8'h10, 8'h00},
		'{8'h00, 8'h01, 2'd1, 8'hFF, 7'h40, 8'h20, 8'hF8},
		'{8'hFF, 8'h03, 2'd2, 8'h80, 7'h41, 8'h40, 8'h08},
		'{8'h03, 8'h00, 2'd0, 8'h01, 7'h01, 8'h70, 8'h80}};
	acg_top acg_top_i (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o),
		.sda_oe(sda_oe), .hsync_in(hsync_in), .green_sync_input(green_sync_input),
		.adc_code(adc_code), .clamp_active(clamp_active),
		.green_sync_threshold(green_sync_threshold), .chan_out(chan_out));
	acg_src_model acg_src_model_i (.clk(clk), .hsync_in(hsync_in),
		.green_sync_input(green_sync_input), .adc_code(adc_code));
	initial clk = 1'b0;
	always #20 clk = ~clk;
	task automatic complete_run;
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk_v(input logic [11:0] got, input logic [11:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk_v
	task automatic chk_t(input int got, input int lo, input int hi, input string m);
		comparisons++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("BAD %0t %s took %0d", $time, m, got);
		end
	endtask : chk_t
	task automatic hold(input int k);
		repeat (k) @(negedge clk);
	endtask : hold
	// slow edges: the synchronised sampler needs several clocks per phase
	task automatic sbit(input logic b, output logic o);
		sda_m = b;
		hold(6);
		scl = 1'b1;
		hold(6);
		o = sda_w;
		scl = 1'b0;
		hold(2);
	endtask : sbit
	task automatic start;
		sda_m = 1'b1;
		hold(6);
		scl = 1'b1;
		hold(6);
		sda_m = 1'b0;
		hold(6);
		scl = 1'b0;
		hold(2);
	endtask : start
	task automatic stop;
		sda_m = 1'b0;
		hold(6);
		scl = 1'b1;
		hold(6);
		sda_m = 1'b1;
		hold(6);
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic ck, output logic [7:0] o);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			sbit(d[i], o[i]);
		end
		sbit(1'b1, a);
		if (ck) chk_v(12'(a), 12'h000, "ack");
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] o;
		start();
		xfer({`ACG_I2C_ADDR, 1'b0}, 1'b1, o);
		xfer(a, 1'b1, o);
		xfer(d, 1'b1, o);
		stop();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] o;
		start();
		xfer({`ACG_I2C_ADDR, 1'b0}, 1'b1, o);
		xfer(a, 1'b1, o);
		start();
		xfer({`ACG_I2C_ADDR, 1'b1}, 1'b1, o);
		xfer(8'hFF, 1'b0, d);
		stop();
	endtask : rd
	task automatic measure(output int rr, output int ww);
		rr = 0;
		ww = 0;
		while (clamp_active !== 1'b1 && rr < 300) begin
			hold(1);
			rr++;
		end
		while (clamp_active === 1'b1 && ww < 300) begin
			hold(1);
			ww++;
		end
	endtask : measure
	// hang guard, well beyond the expected run length
	initial begin
		#(40 * 80000);
		fail_count++;
		complete_run();
	end
	initial begin
		rst_n = 1'b0;
		scl = 1'b1;
		sda_m = 1'b1;
		fail_count = 0;
		comparisons = 0;
		hold(3);
		rst_n = 1'b1;
		hold(4);
		chk_v(12'(clamp_active), 12'h000, "clamp idle");
		chk_v(12'(sda_o), 12'h000, "pull value");
		chk_v(12'(green_sync_threshold), 12'h00F, "thr reset");
		chk_v(12'(chan_out[1].range_mv), 12'd750, "range reset");
		foreach (ra[k]) begin
			rd(ra[k], q);
			chk_v(12'(q), 12'(rv[k]), "reset rd");
		end
		foreach (rows[k]) begin
			x = rows[k];
			wr(`ACG_REG_DELAY, x.d);
			wr(`ACG_REG_LEN, x.n);
			wr(8'(`ACG_REG_GAIN0 + x.ch), x.g);
			wr(8'(`ACG_REG_SHIFT0 + x.ch), {1'b0, x.s});
			wr(`ACG_REG_CLSEL, x.cl);
			wr(`ACG_REG_SOG, x.th);
			rd(`ACG_REG_DELAY, q);
			chk_v(12'(q), 12'(x.d), "delay rd");
			rd(8'(`ACG_REG_SHIFT0 + x.ch), q);
			chk_v(12'(q), 12'({1'b0, x.s}), "shift rd");
			acg_src_model_i.line(1'b0);
			measure(r, w);
			chk_t(r, x.n != 0 ? x.d + 4 : 300, x.n != 0 ? x.d + 5 : 300, "place");
			chk_t(w, x.n, x.n, "length");
			c = chan_out[x.ch];
			chk_v(12'(c.range_mv), 12'(500 + x.g * 500 / 255), "range");
			chk_v(c.step_uv, 12'(2000 + x.g * 2000 / 255), "step");
			chk_v(12'(c.shift), 12'(x.s == 7'h40 ? 7'h41 : x.s), "shift");
			chk_v(12'(c.target), x.cl[4 + x.ch] ? 12'h080 : 12'h000, "target");
			chk_v(12'(green_sync_threshold), 12'(x.th[7:3]), "thr");
		end
		// clamp loop: ch0 above ground, ch1 on ground, ch2 below midscale
		wr(`ACG_REG_CLSEL, 8'h40);
		wr(`ACG_REG_DELAY, 8'h02);
		wr(`ACG_REG_LEN, 8'h0A);
		acg_src_model_i.set_codes({8'h20, 8'h00, 8'h10});
		hold(2);
		snap = chan_out;
		acg_src_model_i.line(1'b0);
		measure(r, w);
		hold(2);
		chk_v(12'(chan_out[0].trim), 12'(8'(snap[0].trim - 8'd10)), "trim dn");
		chk_v(12'(chan_out[1].trim), 12'(snap[1].trim), "trim eq");
		chk_v(12'(chan_out[2].trim), 12'(8'(snap[2].trim + 8'd10)), "trim up");
		// second edge inside placement restarts the count
		wr(`ACG_REG_DELAY, 8'h14);
		wr(`ACG_REG_LEN, 8'h05);
		acg_src_model_i.line(1'b0);
		hold(10);
		acg_src_model_i.line(1'b0);
		measure(r, w);
		chk_t(r, 24, 25, "restart");
		// edge inside an open window drops it and starts over
		wr(`ACG_REG_DELAY, 8'h02);
		wr(`ACG_REG_LEN, 8'h1E);
		acg_src_model_i.line(1'b0);
		hold(8);
		acg_src_model_i.line(1'b0);
		n = 0;
		while (clamp_active === 1'b1 && n < 8) begin
			hold(1);
			n++;
		end
		chk_t(n, 3, 4, "drop");
		measure(r, w);
		chk_t(r + n, 6, 7, "again");
		chk_t(w, 30, 30, "again len");
		// active-low sync: trailing edge is the rise
		acg_src_model_i.set_pol(1'b0);
		wr(`ACG_REG_SYNC, 8'h00);
		acg_src_model_i.line(1'b0);
		measure(r, w);
		chk_t(r, 6, 7, "low pol");
		// green source ignores the polarity bit
		for (int p = 0; p < 2; p++) begin
			wr(`ACG_REG_SYNC, p != 0 ? 8'h48 : 8'h08);
			acg_src_model_i.line(1'b1);
			measure(r, w);
			chk_t(r, 6, 7, "green");
		end
		// status: a sync edge was seen, window closed, not placing
		rd(`ACG_REG_STAT, q);
		chk_v(12'(q), 12'h004, "status");
		complete_run();
	end
endmodule : tb_adc_clamp_gain_offset_control
`default_nettype wire
